// ---- hw/fopm_pkg.sv ----
// package: register map, field layout, modes and timing constants for the fast output block
package fopm_pkg;

  // clock rate and duty scale
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned DUTY_FULL_COUNT = 32_000;
  localparam logic [31:0] DUTY_FULL       = 32'h0000_7D00;

  // bus geometry
  localparam int unsigned AXI_AW = 12;
  localparam int unsigned AXI_DW = 32;

  // byte addresses of the global registers
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_MCFG   = 12'h004;
  localparam logic [11:0] ADDR_STAT   = 12'h008;
  localparam logic [11:0] ADDR_ISTAT  = 12'h00C;
  localparam logic [11:0] ADDR_IMASK  = 12'h010;
  // counter pages start at 0x020 (counter 0) and 0x040 (counter 1)
  localparam logic [11:0] ADDR_CNT_BASE = 12'h020;
  // modulator pages start at 0x060 (channel 0) and 0x080 (channel 1)
  localparam logic [11:0] ADDR_PWM_BASE = 12'h060;
  localparam logic [11:0] PAGE_STRIDE   = 12'h020;

  // page numbers (address bits 7:5) and word indices inside a page
  localparam logic [2:0] PAGE_GLOBAL = 3'h0;
  localparam logic [2:0] PAGE_CNT0   = 3'h1;
  localparam logic [2:0] PAGE_PWM0   = 3'h3;
  localparam logic [2:0] CNT_W_ACC   = 3'h0;
  localparam logic [2:0] CNT_W_LATCH = 3'h1;
  localparam logic [2:0] CNT_W_PRE   = 3'h2;
  localparam logic [2:0] CNT_W_MA    = 3'h3;
  localparam logic [2:0] CNT_W_MB    = 3'h4;
  localparam logic [2:0] PWM_W_DUTY  = 3'h0;
  localparam logic [2:0] PWM_W_FREQ  = 3'h1;
  localparam logic [2:0] PWM_W_SDUTY = 3'h2;
  localparam logic [2:0] PWM_W_SFREQ = 3'h3;

  // control register fields (two bits of mode per channel, one bit of each flag per channel)
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_DOUT_LSB = 4;
  localparam int unsigned CTRL_HOLD_LSB = 6;
  localparam int unsigned CTRL_EN_LSB   = 8;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0000;

  // match config: two bits per match value, two match values per counter
  localparam logic [31:0] MCFG_RST  = 32'h0000_0000;
  localparam logic [31:0] IMASK_RST = 32'h0000_0000;
  localparam logic [31:0] WORD_RST  = 32'h0000_0000;

  // status nibble per counter (counter n at bits 4n+3..4n)
  localparam int unsigned ST_OVF   = 0;
  localparam int unsigned ST_UNF   = 1;
  localparam int unsigned ST_OUT   = 2;
  localparam int unsigned ST_MATCH = 3;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_PLAIN = 2'b00,
    MODE_PWM   = 2'b01,
    MODE_MATCH = 2'b10,
    MODE_STEP  = 2'b11
  } fopm_mode_e;

  typedef enum logic [1:0] {
    ACT_NONE   = 2'b00,
    ACT_ON     = 2'b01,
    ACT_OFF    = 2'b10,
    ACT_TOGGLE = 2'b11
  } fopm_act_e;

  typedef enum logic [2:0] {
    RG_NONE  = 3'b000,
    RG_CTRL  = 3'b001,
    RG_MCFG  = 3'b010,
    RG_STAT  = 3'b011,
    RG_ISTAT = 3'b100,
    RG_IMASK = 3'b101,
    RG_CNT   = 3'b110,
    RG_PWM   = 3'b111
  } fopm_rg_e;

  // decoded register address
  typedef struct packed {
    fopm_rg_e   rg;
    logic       ch;
    logic [2:0] word;
  } fopm_dec_s;

  // what the counter logic hands to this block each cycle
  typedef struct packed {
    logic [31:0] acc;
    logic [31:0] latch;
    logic        upd;
    logic        ovf;
    logic        unf;
  } fopm_cnt_s;

endpackage

// ---- hw/fopm_top.sv ----
// fast output channels: plain, modulated and compare-driven outputs behind an axi4-lite slave
//
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - counter compared to both match values, acts
// - two outputs, each one of four modes
// - plain mode drives pin from output bit
// - modulation mode: independent enable, frequency, duty
// - duty 0..32000 sets high fraction
// - duty 0 off, 32000 always on
// - frequency in hertz sets period
// - live setting changes apply without restart
// - output low until frequency and duty nonzero
// - stop mode: hold state or stop settings
// - zero stop setting holds output low
// - counter n compare drives output n
// - readable overflow, underflow and output state
module fopm_top
  import fopm_pkg::*;
#(
  parameter int unsigned CLK_FREQ_HZ = fopm_pkg::CLK_HZ
) (
  // clock and reset
  input  wire logic                       I_MCLK,
  input  wire logic                       I_NRST,
  // axi4-lite write address and data
  input  wire logic [fopm_pkg::AXI_AW-1:0] I_AWADDR,
  input  wire logic                       I_AWVALID,
  output logic                            O_AWREADY,
  input  wire logic [31:0]                I_WDATA,
  input  wire logic [3:0]                 I_WSTRB,
  input  wire logic                       I_WVALID,
  output logic                            O_WREADY,
  // axi4-lite write response
  output logic [1:0]                      O_BRESP,
  output logic                            O_BVALID,
  input  wire logic                       I_BREADY,
  // axi4-lite read
  input  wire logic [fopm_pkg::AXI_AW-1:0] I_ARADDR,
  input  wire logic                       I_ARVALID,
  output logic                            O_ARREADY,
  output logic [31:0]                     O_RDATA,
  output logic [1:0]                      O_RRESP,
  output logic                            O_RVALID,
  input  wire logic                       I_RREADY,
  // counter logic and controller state, same clock
  input  wire fopm_pkg::fopm_cnt_s [1:0]  I_CNT,
  input  wire logic                       I_STOP,
  // outputs
  output logic [1:0][31:0]                O_PRELOAD,
  output logic [1:0]                      O_FAST_OUT,
  output logic                            O_IRQ
);
  import fopm_pkg::*;

  localparam logic [31:0] DUTY_STEP = 32'(CLK_FREQ_HZ / DUTY_FULL_COUNT);
  localparam logic [32:0] CLK_W     = 33'(CLK_FREQ_HZ);

  // refuse a clock the duty scale cannot divide
  if ((CLK_FREQ_HZ % DUTY_FULL_COUNT) != 0 || CLK_FREQ_HZ < DUTY_FULL_COUNT) begin : g_bad_clk
    $error("clock rate must be a multiple of the duty scale");
  end

  // address decode shared by the read and write paths
  function automatic fopm_dec_s decode(input logic [AXI_AW-1:0] a);
    fopm_dec_s d;
    d = '{rg: RG_NONE, ch: 1'b0, word: a[4:2]};
    if (a[AXI_AW-1:8] == '0 && a[1:0] == 2'h0) begin
      if (a[7:5] == PAGE_GLOBAL) begin
        unique case (a[4:2])
          3'h0: d.rg = RG_CTRL;
          3'h1: d.rg = RG_MCFG;
          3'h2: d.rg = RG_STAT;
          3'h3: d.rg = RG_ISTAT;
          3'h4: d.rg = RG_IMASK;
          default: d.rg = RG_NONE;
        endcase
      end else if ((a[7:5] == PAGE_CNT0 || a[7:5] == PAGE_CNT0 + 3'h1) && a[4:2] <= CNT_W_MB) begin
        d.rg = RG_CNT;
        d.ch = a[7:5] != PAGE_CNT0;
      end else if ((a[7:5] == PAGE_PWM0 || a[7:5] == PAGE_PWM0 + 3'h1)
                   && a[4:2] <= PWM_W_SFREQ) begin
        d.rg = RG_PWM;
        d.ch = a[7:5] != PAGE_PWM0;
      end
    end
    return d;
  endfunction

  // merge write data into a word by byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // modulated level for one cycle, from phase within the period
  function automatic logic pwm_level(input logic [31:0] phase, input logic [31:0] duty,
                                     input logic [31:0] freq);
    logic [63:0] thr;
    thr = 64'(duty) * 64'(DUTY_STEP);
    if (duty >= DUTY_FULL) begin
      pwm_level = 1'b1;
    end else if (duty == 32'h0000_0000 || freq == 32'h0000_0000) begin
      pwm_level = 1'b0;
    end else begin
      pwm_level = 64'(phase) < thr;
    end
  endfunction

  // bus side state
  logic              awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic              aw_full_r, w_full_r;
  logic [AXI_AW-1:0] awaddr_r;
  logic [31:0]       wdata_r, rdata_r;
  logic [3:0]        wstrb_r;
  logic [1:0]        bresp_r, rresp_r;
  // software registers
  logic [31:0]       ctrl_r, mcfg_r, imask_r;
  logic [7:0]        istat_r;
  logic [1:0][31:0]  pre_r, ma_r, mb_r;
  logic [1:0][31:0]  duty_r, freq_r, sduty_r, sfreq_r;
  logic              irq_r;
  // block state gathered from the channels
  logic [1:0]        fast_r;
  logic [1:0]        pwm_lvl;
  logic [1:0]        match_ev;
  logic [31:0]       stat_w;
  logic [7:0]        ev_w;
  logic              wr_go;
  fopm_dec_s         wdec, rdec;

  assign wdec  = decode(awaddr_r);
  assign rdec  = decode(I_ARADDR);
  assign wr_go = aw_full_r && w_full_r && !bvalid_r;

  // write address and data are taken independently, in either order
  always_ff @(posedge I_MCLK) begin
    if (!I_NRST) begin
      awready_r <= 1'b0;
      aw_full_r <= 1'b0;
      awaddr_r  <= '0;
    end else if (I_AWVALID && awready_r) begin
      awready_r <= 1'b0;
      aw_full_r <= 1'b1;
      awaddr_r  <= I_AWADDR;
    end else begin
      awready_r <= I_AWVALID && !aw_full_r && !bvalid_r;
      if (wr_go) begin
        aw_full_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_NRST) begin
      wready_r <= 1'b0;
      w_full_r <= 1'b0;
      wdata_r  <= '0;
      wstrb_r  <= '0;
    end else if (I_WVALID && wready_r) begin
      wready_r <= 1'b0;
      w_full_r <= 1'b1;
      wdata_r  <= I_WDATA;
      wstrb_r  <= I_WSTRB;
    end else begin
      wready_r <= I_WVALID && !w_full_r && !bvalid_r;
      if (wr_go) begin
        w_full_r <= 1'b0;
      end
    end
  end

  // write response follows both halves; unmapped or read-only targets answer slverr
  always_ff @(posedge I_MCLK) begin
    if (!I_NRST) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= (wdec.rg == RG_NONE || wdec.rg == RG_STAT
                   || (wdec.rg == RG_CNT && wdec.word < CNT_W_PRE)) ? RESP_SLVERR : RESP_OKAY;
    end else if (I_BREADY && bvalid_r) begin
      bvalid_r <= 1'b0;
    end
  end

  // software writable registers
  always_ff @(posedge I_MCLK) begin
    if (!I_NRST) begin
      ctrl_r  <= CTRL_RST;
      mcfg_r  <= MCFG_RST;
      imask_r <= IMASK_RST;
      pre_r   <= '{default: WORD_RST};
      ma_r    <= '{default: WORD_RST};
      mb_r    <= '{default: WORD_RST};
      duty_r  <= '{default: WORD_RST};
      freq_r  <= '{default: WORD_RST};
      sduty_r <= '{default: WORD_RST};
      sfreq_r <= '{default: WORD_RST};
    end else if (wr_go) begin
      unique case (wdec.rg)
        RG_CTRL:  ctrl_r  <= merge(ctrl_r, wdata_r, wstrb_r);
        RG_MCFG:  mcfg_r  <= merge(mcfg_r, wdata_r, wstrb_r);
        RG_IMASK: imask_r <= merge(imask_r, wdata_r, wstrb_r);
        RG_CNT: begin
          if (wdec.word == CNT_W_PRE) pre_r[wdec.ch] <= merge(pre_r[wdec.ch], wdata_r, wstrb_r);
          if (wdec.word == CNT_W_MA)  ma_r[wdec.ch]  <= merge(ma_r[wdec.ch], wdata_r, wstrb_r);
          if (wdec.word == CNT_W_MB)  mb_r[wdec.ch]  <= merge(mb_r[wdec.ch], wdata_r, wstrb_r);
        end
        RG_PWM: begin
          unique case (wdec.word)
            PWM_W_DUTY:  duty_r[wdec.ch]  <= merge(duty_r[wdec.ch], wdata_r, wstrb_r);
            PWM_W_FREQ:  freq_r[wdec.ch]  <= merge(freq_r[wdec.ch], wdata_r, wstrb_r);
            PWM_W_SDUTY: sduty_r[wdec.ch] <= merge(sduty_r[wdec.ch], wdata_r, wstrb_r);
            default:     sfreq_r[wdec.ch] <= merge(sfreq_r[wdec.ch], wdata_r, wstrb_r);
          endcase
        end
        default: ;
      endcase
    end
  end

  // events of both counters in status-nibble layout
  always_comb begin
    ev_w   = '0;
    stat_w = '0;
    for (int c = 0; c < 2; c++) begin
      ev_w[c*4 + ST_OVF]     = I_CNT[c].ovf;
      ev_w[c*4 + ST_UNF]     = I_CNT[c].unf;
      ev_w[c*4 + ST_MATCH]   = match_ev[c];
      stat_w[c*4 + ST_OVF]   = istat_r[c*4 + ST_OVF];
      stat_w[c*4 + ST_UNF]   = istat_r[c*4 + ST_UNF];
      stat_w[c*4 + ST_OUT]   = fast_r[c];
      stat_w[c*4 + ST_MATCH] = istat_r[c*4 + ST_MATCH];
    end
  end

  // sticky event bits, write one to clear; a new event beats the clear
  always_ff @(posedge I_MCLK) begin
    if (!I_NRST) begin
      istat_r <= '0;
    end else if (wr_go && wdec.rg == RG_ISTAT && wstrb_r[0]) begin
      istat_r <= (istat_r & ~wdata_r[7:0]) | ev_w;
    end else begin
      istat_r <= istat_r | ev_w;
    end
  end

  // level interrupt from unmasked status
  always_ff @(posedge I_MCLK) begin
    if (!I_NRST) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(istat_r & imask_r[7:0]);
    end
  end

  // read channel: one address at a time, data registered
  always_ff @(posedge I_MCLK) begin
    if (!I_NRST) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= RESP_OKAY;
    end else if (I_ARVALID && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rresp_r   <= (rdec.rg == RG_NONE) ? RESP_SLVERR : RESP_OKAY;
      unique case (rdec.rg)
        RG_CTRL:  rdata_r <= ctrl_r;
        RG_MCFG:  rdata_r <= mcfg_r;
        RG_STAT:  rdata_r <= stat_w;
        RG_ISTAT: rdata_r <= {24'h00_0000, istat_r};
        RG_IMASK: rdata_r <= imask_r;
        RG_CNT: begin
          unique case (rdec.word)
            CNT_W_ACC:   rdata_r <= I_CNT[rdec.ch].acc;
            CNT_W_LATCH: rdata_r <= I_CNT[rdec.ch].latch;
            CNT_W_PRE:   rdata_r <= pre_r[rdec.ch];
            CNT_W_MA:    rdata_r <= ma_r[rdec.ch];
            default:     rdata_r <= mb_r[rdec.ch];
          endcase
        end
        RG_PWM: begin
          unique case (rdec.word)
            PWM_W_DUTY:  rdata_r <= duty_r[rdec.ch];
            PWM_W_FREQ:  rdata_r <= freq_r[rdec.ch];
            PWM_W_SDUTY: rdata_r <= sduty_r[rdec.ch];
            default:     rdata_r <= sfreq_r[rdec.ch];
          endcase
        end
        default: rdata_r <= 32'h0000_0000;
      endcase
    end else begin
      arready_r <= I_ARVALID && !rvalid_r;
      if (I_RREADY && rvalid_r) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // per-channel modulator, compare logic and output select
  for (genvar g = 0; g < 2; g++) begin : g_ch
    logic        armed_r, lvl_r, match_st_r, hit_r;
    logic [31:0] phase_r;
    logic [31:0] use_duty, use_freq, inc;
    logic [32:0] sum;
    logic        eq_a, eq_b, hold, en;
    fopm_mode_e  mode;
    fopm_act_e   act_a, act_b;

    assign mode  = fopm_mode_e'(ctrl_r[CTRL_MODE_LSB + 2*g +: 2]);
    assign hold  = ctrl_r[CTRL_HOLD_LSB + g];
    assign en    = ctrl_r[CTRL_EN_LSB + g];
    assign act_a = fopm_act_e'(mcfg_r[4*g +: 2]);
    assign act_b = fopm_act_e'(mcfg_r[4*g + 2 +: 2]);

    // stop mode switches to the stop settings, also while holding
    assign use_duty = I_STOP ? sduty_r[g] : duty_r[g];
    assign use_freq = I_STOP ? sfreq_r[g] : freq_r[g];
    assign inc      = (33'(use_freq) > CLK_W) ? CLK_W[31:0] : use_freq;
    assign sum      = 33'(phase_r) + 33'(inc);

    // phase walks by the frequency each cycle and wraps at the clock rate
    always_ff @(posedge I_MCLK) begin
      if (!I_NRST) begin
        phase_r <= 32'h0000_0000;
      end else if (sum >= CLK_W) begin
        phase_r <= 32'(sum - CLK_W);
      end else begin
        phase_r <= sum[31:0];
      end
    end

    // output stays off after reset until both settings are nonzero
    always_ff @(posedge I_MCLK) begin
      if (!I_NRST) begin
        armed_r <= 1'b0;
      end else if (duty_r[g] != 32'h0000_0000 && freq_r[g] != 32'h0000_0000) begin
        armed_r <= 1'b1;
      end
    end

    // modulated level
    always_ff @(posedge I_MCLK) begin
      if (!I_NRST) begin
        lvl_r <= 1'b0;
      end else if (!en || !armed_r) begin
        lvl_r <= 1'b0;
      end else if (I_STOP && hold) begin
        lvl_r <= lvl_r;
      end else if (I_STOP && (use_duty == 32'h0000_0000 || use_freq == 32'h0000_0000)) begin
        lvl_r <= 1'b0;
      end else begin
        lvl_r <= pwm_level(phase_r, use_duty, use_freq);
      end
    end
    assign pwm_lvl[g] = lvl_r;

    // compare on each accumulator update; second match applied after the first
    assign eq_a = I_CNT[g].acc == ma_r[g];
    assign eq_b = I_CNT[g].acc == mb_r[g];
    always_ff @(posedge I_MCLK) begin
      if (!I_NRST) begin
        match_st_r <= 1'b0;
        hit_r      <= 1'b0;
      end else begin
        hit_r <= I_CNT[g].upd && (eq_a || eq_b);
        if (I_CNT[g].upd) begin
          match_st_r <= next_state(next_state(match_st_r, eq_a, act_a), eq_b, act_b);
        end
      end
    end
    assign match_ev[g] = hit_r;

    // output select per mode; stepper is not served here and reads low
    always_ff @(posedge I_MCLK) begin
      if (!I_NRST) begin
        fast_r[g] <= 1'b0;
      end else begin
        unique case (mode)
          MODE_PLAIN: fast_r[g] <= ctrl_r[CTRL_DOUT_LSB + g];
          MODE_PWM:   fast_r[g] <= pwm_lvl[g];
          MODE_MATCH: fast_r[g] <= match_st_r;
          MODE_STEP:  fast_r[g] <= 1'b0;
        endcase
      end
    end
  end

  // compare action applied to the current compare state
  function automatic logic next_state(input logic cur, input logic hit, input fopm_act_e act);
    if (!hit) begin
      return cur;
    end
    unique case (act)
      ACT_ON:     return 1'b1;
      ACT_OFF:    return 1'b0;
      ACT_TOGGLE: return !cur;
      ACT_NONE:   return cur;
    endcase
  endfunction

  // port drive from flops
  assign O_AWREADY  = awready_r;
  assign O_WREADY   = wready_r;
  assign O_BVALID   = bvalid_r;
  assign O_BRESP    = bresp_r;
  assign O_ARREADY  = arready_r;
  assign O_RVALID   = rvalid_r;
  assign O_RDATA    = rdata_r;
  assign O_RRESP    = rresp_r;
  assign O_PRELOAD  = pre_r;
  assign O_FAST_OUT = fast_r;
  assign O_IRQ      = irq_r;

endmodule

`default_nettype wire

// ---- testbench/fopm_chk_asserts.sv ----
// checker: bus handshake and output properties seen at the block's ports
`timescale 1ns/1ps
`default_nettype none
module fopm_chk (
  // clock and reset
  input wire logic        I_MCLK,
  input wire logic        I_NRST,
  // bus handshakes
  input wire logic        I_AWVALID,
  input wire logic        I_WVALID,
  input wire logic        I_BREADY,
  input wire logic        I_ARVALID,
  input wire logic        I_RREADY,
  input wire logic        O_AWREADY,
  input wire logic        O_WREADY,
  input wire logic [1:0]  O_BRESP,
  input wire logic        O_BVALID,
  input wire logic        O_ARREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic [1:0]  O_RRESP,
  input wire logic        O_RVALID,
  // pins
  input wire logic [1:0]  O_FAST_OUT,
  input wire logic        O_IRQ
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_NRST);

  // both write halves taken at one edge
  sequence s_wr_take;
    I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
  endsequence
  // read address taken
  sequence s_rd_take;
    I_ARVALID && O_ARREADY;
  endsequence

  AST_RST_OUT: assert property ($rose(I_NRST) |-> !O_FAST_OUT && !O_IRQ && !O_BVALID && !O_RVALID)
    else $error("outputs not clear after reset");
  AST_PWM_ARM: assert property ($rose(I_NRST) |-> (O_FAST_OUT == 2'h0)[*3])
    else $error("fast output moved right after reset");
  AST_B_HOLD: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable({O_RDATA, O_RRESP}))
    else $error("read data dropped early");
  AST_B_ANSWER: assert property (s_wr_take |-> ##2 O_BVALID)
    else $error("write response late");
  AST_R_ANSWER: assert property (s_rd_take |=> O_RVALID ##0 !O_ARREADY)
    else $error("read answer late");
  AST_AR_BLOCK: assert property (O_RVALID |-> !O_ARREADY)
    else $error("read address taken while data pending");
  AST_AW_BLOCK: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
    else $error("write taken while response pending");
  AST_RDY_PULSE: assert property (O_AWREADY && I_AWVALID |=> !O_AWREADY)
    else $error("write address ready held too long");
endmodule

bind fopm_top fopm_chk u_chk (.I_MCLK, .I_NRST, .I_AWVALID, .I_WVALID, .I_BREADY, .I_ARVALID,
  .I_RREADY, .O_AWREADY, .O_WREADY, .O_BRESP, .O_BVALID, .O_ARREADY, .O_RDATA, .O_RRESP,
  .O_RVALID, .O_FAST_OUT, .O_IRQ);
`default_nettype wire

// ---- testbench/fopm_load.sv ----
// model of the loads on the two fast output pins: high time and rising edges
`timescale 1ns/1ps
`default_nettype none
module fopm_load (
  // clock, reset, pins
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [1:0]  i_pin,
  // running tallies per pin
  output logic [1:0][31:0] o_hi,
  output logic [1:0][31:0] o_rise
);
  logic [1:0] last_r;

  // tally level and edges every cycle
  always_ff @(posedge i_clk) begin
    last_r <= i_pin;
    for (int c = 0; c < 2; c++) begin
      o_hi[c]   <= i_rst_n ? o_hi[c] + 32'(i_pin[c]) : 32'h0;
      o_rise[c] <= i_rst_n ? o_rise[c] + 32'(i_pin[c] & ~last_r[c]) : 32'h0;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/fopm_top_tb.sv ----
// self-checking bench for the fast output block
`timescale 1ns/1ps
`default_nettype none
module fopm_top_tb;
  import fopm_pkg::*;
  localparam int          LIMIT = 40000;
  localparam logic [31:0] SKIP  = 32'hFFFF_FFFF;
  // bench-driven inputs
  logic             clk     = 1'b0;
  logic             rstn    = 1'b0;
  logic [11:0]      awaddr  = 12'h000;
  logic [11:0]      araddr  = 12'h000;
  logic [31:0]      wdata   = 32'h0;
  logic [3:0]       wstrb   = 4'hF;
  logic             awvalid = 1'b0;
  logic             wvalid  = 1'b0;
  logic             bready  = 1'b0;
  logic             arvalid = 1'b0;
  logic             rready  = 1'b0;
  logic             stp     = 1'b0;
  fopm_cnt_s [1:0]  cnt     = '0;
  // design outputs and load tallies
  logic             aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, irq;
  logic [1:0]       bresp, rresp, fo;
  logic [31:0]      rdata;
  logic [1:0][31:0] pre, ld_hi, ld_rise;
  int               err_count = 0;
  int               compares  = 0;
  int               cyc       = 0;

  fopm_top #(.CLK_FREQ_HZ(3_200_000)) dut (
    .I_MCLK(clk), .I_NRST(rstn), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(aw_rdy),
    .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(w_rdy), .O_BRESP(bresp),
    .O_BVALID(b_vld), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
    .O_ARREADY(ar_rdy), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(r_vld), .I_RREADY(rready),
    .I_CNT(cnt), .I_STOP(stp), .O_PRELOAD(pre), .O_FAST_OUT(fo), .O_IRQ(irq));
  fopm_load u_ld (.i_clk(clk), .i_rst_n(rstn), .i_pin(fo), .o_hi(ld_hi), .o_rise(ld_rise));

  // 200 MHz clock
  always #2.5 clk = ~clk;

  task automatic conclude();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bus write, response code compared
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awvalid && aw_rdy) awvalid <= 1'b0;
      if (wvalid && w_rdy) wvalid <= 1'b0;
      if (b_vld) break;
    end
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
    @(posedge clk);
  endtask

  // bus read, data and response compared
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arvalid && ar_rdy) arvalid <= 1'b0;
      if (r_vld) break;
    end
    rready <= 1'b0;
    chk(rdata, e);
    chk(32'(rresp), 32'(er));
    @(posedge clk);
  endtask

  // settle, then tally both pins over 1000 cycles
  task automatic meas(input logic [31:0] h0, input logic [31:0] h1,
                      input logic [31:0] e0, input logic [31:0] e1);
    logic [1:0][31:0] hs;
    logic [1:0][31:0] es;
    repeat (200) @(posedge clk);
    hs = ld_hi;
    es = ld_rise;
    repeat (1000) @(posedge clk);
    if (h0 !== SKIP) chk(ld_hi[0] - hs[0], h0);
    chk(ld_hi[1] - hs[1], h1);
    chk(ld_rise[0] - es[0], e0);
    chk(ld_rise[1] - es[1], e1);
  endtask

  // one accumulator update pulse on counter c
  task automatic upd(input int c, input logic [31:0] v);
    cnt[c].acc <= v;
    cnt[c].upd <= 1'b1;
    @(posedge clk);
    cnt[c].upd <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // run-length guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      conclude();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    cnt[0].acc <= 32'h1234;
    cnt[0].latch <= 32'h55AA;
    @(posedge clk);
    // reset values, read-only and unmapped places
    rd(ADDR_CTRL, CTRL_RST, RESP_OKAY);
    rd(ADDR_MCFG, MCFG_RST, RESP_OKAY);
    rd(ADDR_IMASK, IMASK_RST, RESP_OKAY);
    rd(12'h060, WORD_RST, RESP_OKAY);
    rd(12'h0FC, 32'h0, RESP_SLVERR);
    wr(ADDR_STAT, 32'hFF, RESP_SLVERR);
    wr(12'h020, 32'h5, RESP_SLVERR);
    rd(12'h020, 32'h1234, RESP_OKAY);
    rd(12'h024, 32'h55AA, RESP_OKAY);
    wr(12'h028, 32'hCAFE_0001, RESP_OKAY);
    chk(pre[0], 32'hCAFE_0001);
    wr(12'h048, 32'h0BAD_0002, RESP_OKAY);
    chk(pre[1], 32'h0BAD_0002);
    // plain mode follows the output bits
    wr(ADDR_CTRL, 32'h30, RESP_OKAY);
    chk(32'(fo), 32'h3);
    wr(ADDR_CTRL, 32'h10, RESP_OKAY);
    chk(32'(fo), 32'h1);
    rd(ADDR_STAT, 32'h4, RESP_OKAY);
    // modulator zero stays low until both words are nonzero
    wr(ADDR_CTRL, 32'h101, RESP_OKAY);
    wr(12'h064, 32'h7D00, RESP_OKAY);
    meas(32'h0, 32'h0, 32'h0, 32'h0);
    wr(12'h060, 32'h1F40, RESP_OKAY);
    meas(32'hFA, 32'h0, 32'hA, 32'h0);
    wr(12'h060, 32'h3E80, RESP_OKAY);
    wr(12'h064, 32'hFA00, RESP_OKAY);
    meas(32'h1F4, 32'h0, 32'h14, 32'h0);
    // second modulator with its own words
    wr(12'h084, 32'h3E80, RESP_OKAY);
    wr(12'h080, 32'h7080, RESP_OKAY);
    wr(ADDR_CTRL, 32'h305, RESP_OKAY);
    meas(32'h1F4, 32'h384, 32'h14, 32'h5);
    wr(12'h060, DUTY_FULL, RESP_OKAY);
    meas(32'h3E8, 32'h384, 32'h0, 32'h5);
    wr(12'h060, 32'h0, RESP_OKAY);
    meas(32'h0, 32'h384, 32'h0, 32'h5);
    // stop mode: zero stop words, then stop words, then hold
    stp <= 1'b1;
    meas(32'h0, 32'h0, 32'h0, 32'h0);
    wr(12'h068, 32'h1F40, RESP_OKAY);
    wr(12'h06C, 32'h7D00, RESP_OKAY);
    meas(32'hFA, 32'h0, 32'hA, 32'h0);
    stp <= 1'b0;
    wr(12'h060, 32'h3E80, RESP_OKAY);
    wr(ADDR_CTRL, 32'h345, RESP_OKAY);
    stp <= 1'b1;
    meas(SKIP, 32'h0, 32'h0, 32'h0);
    stp <= 1'b0;
    // compare-driven outputs: on, off, toggle, none
    wr(ADDR_CTRL, 32'hA, RESP_OKAY);
    wr(ADDR_MCFG, 32'h39, RESP_OKAY);
    wr(12'h02C, 32'h64, RESP_OKAY);
    wr(12'h030, 32'hC8, RESP_OKAY);
    wr(12'h04C, 32'h32, RESP_OKAY);
    wr(12'h050, 32'h46, RESP_OKAY);
    wr(ADDR_IMASK, 32'h8, RESP_OKAY);
    upd(1, 32'h64);
    chk(32'(fo), 32'h0);
    upd(0, 32'h64);
    chk(32'(fo), 32'h1);
    chk(32'(irq), 32'h1);
    upd(0, 32'h96);
    chk(32'(fo), 32'h1);
    upd(1, 32'h32);
    chk(32'(fo), 32'h3);
    upd(1, 32'h46);
    chk(32'(fo), 32'h3);
    cnt[1].ovf <= 1'b1;
    cnt[0].unf <= 1'b1;
    @(posedge clk);
    cnt[1].ovf <= 1'b0;
    cnt[0].unf <= 1'b0;
    rd(ADDR_STAT, 32'hDE, RESP_OKAY);
    rd(ADDR_ISTAT, 32'h9A, RESP_OKAY);
    // interrupt cleared, then unmasked on another source
    wr(ADDR_ISTAT, 32'h8, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    wr(ADDR_IMASK, 32'h10, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1);
    wr(ADDR_ISTAT, 32'h10, RESP_OKAY);
    upd(0, 32'hC8);
    chk(32'(fo), 32'h2);
    upd(1, 32'h32);
    chk(32'(fo), 32'h0);
    chk(32'(irq), 32'h0);
    // stepper mode keeps both pins low here
    wr(ADDR_CTRL, 32'h3F, RESP_OKAY);
    chk(32'(fo), 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
